// ### core/ldovr_bank.sv
/*
  level register bank for the second, third and fourth regulators: enable,
  low-power flag, bank chooser, level codes with ceiling clamp and lock.
  assumes an upstream serial slave turns bus traffic into single-cycle
  register strobes on ref_clk_i, and that rstn_i is the power-on reset.
*/
// Operation
// R1: every register reloads its reset contents, programmable defaults included, at power-on reset.
// R2: the enable bit 7 of an adjustable register turns its regulator on unless forced shutdown is active.
// R3: bits 5-0 are a read/write level code with programmable default, and bit 6 of adjustable registers is a low-power flag resetting to 0.
// R4: a written level code above the ceiling is replaced by the ceiling; the fourth regulator keeps bit 5 set even when that exceeds its ceiling.
// R5: a ceiling other than 0x3f or 0x00, from a write or the default, locks the ceiling until reload.
// R6: reserved bits read as zero and the host writes zero into them.
// R7: the fourth regulator keeps the top bit of its level code at 1.
// R8: the registers sit at 14h to 19h in the documented order.
// R9: bit 6 of an operating register chooses operating or adjustable code for the regulator.
`timescale 1ns/100ps
module ldovr_bank (
  input  wire logic       ref_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       wr_en_i,
  input  wire logic       rd_en_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  input  wire logic       force_off_i,
  input  wire logic [7:0] otp_reg2_adj_i,
  input  wire logic [5:0] otp_reg2_ceil_i,
  input  wire logic [5:0] otp_reg3_op_i,
  input  wire logic [7:0] otp_reg3_adj_i,
  input  wire logic [5:0] otp_reg3_ceil_i,
  input  wire logic [5:0] otp_reg4_op_i,
  input  wire logic [5:0] reg4_ceiling_i,
  output logic            reg2_enable_o,
  output logic            reg2_low_power_o,
  output logic      [5:0] reg2_adj_code_o,
  output logic            reg3_enable_o,
  output logic            reg3_low_power_o,
  output logic      [5:0] reg3_level_o,
  output logic      [5:0] reg4_op_code_o,
  output logic            reg4_bank_chooser_o
);
  import ldovr_pkg::*;

  logic       reg2_en;
  logic       reg2_lp;
  logic [5:0] reg2_adj;
  logic       reg3_chooser;
  logic [5:0] reg3_op;
  logic       reg3_en;
  logic       reg3_lp;
  logic [5:0] reg3_adj;
  logic       reg4_chooser;
  logic [5:0] reg4_op;
  logic [5:0] reg2_ceil;
  logic [5:0] reg3_ceil;
  logic       reg2_lock;
  logic       reg3_lock;
  logic [5:0] next_reg2_code;
  logic [5:0] next_reg3_code;
  logic [5:0] next_reg4_code;
  logic [5:0] reg4_forced;
  logic       wr_reg2_adj;
  logic       wr_reg2_ceil;
  logic       wr_reg3_op;
  logic       wr_reg3_adj;
  logic       wr_reg3_ceil;
  logic       wr_reg4_op;

  // R8: address decode
  assign wr_reg2_adj  = wr_en_i && (addr_i == LDOVR_OFS_REG2_ADJ);
  assign wr_reg2_ceil = wr_en_i && (addr_i == LDOVR_OFS_REG2_CEIL);
  assign wr_reg3_op   = wr_en_i && (addr_i == LDOVR_OFS_REG3_OP);
  assign wr_reg3_adj  = wr_en_i && (addr_i == LDOVR_OFS_REG3_ADJ);
  assign wr_reg3_ceil = wr_en_i && (addr_i == LDOVR_OFS_REG3_CEIL);
  assign wr_reg4_op   = wr_en_i && (addr_i == LDOVR_OFS_REG4_OP);

  // R5: ceiling with lock
  // a locked ceiling drops the write silently; the host sees it only on read-back
  ldovr_ceiling u_reg2_ceil (
    .ref_clk_i     (ref_clk_i),
    .rstn_i        (rstn_i),
    .otp_ceiling_i (otp_reg2_ceil_i),
    .wr_i          (wr_reg2_ceil),
    .wdata_i       (wdata_i[5:0]),
    .ceiling_o     (reg2_ceil),
    .locked_o      (reg2_lock)
  );

  ldovr_ceiling u_reg3_ceil (
    .ref_clk_i     (ref_clk_i),
    .rstn_i        (rstn_i),
    .otp_ceiling_i (otp_reg3_ceil_i),
    .wr_i          (wr_reg3_ceil),
    .wdata_i       (wdata_i[5:0]),
    .ceiling_o     (reg3_ceil),
    .locked_o      (reg3_lock)
  );

  // R4: clamp written codes
  // the ceiling in force at the write edge decides; a later ceiling leaves codes alone
  always_comb begin
    next_reg2_code = (wdata_i[5:0] > reg2_ceil) ? reg2_ceil : wdata_i[5:0];
    next_reg3_code = (wdata_i[5:0] > reg3_ceil) ? reg3_ceil : wdata_i[5:0];
  end

  // R7: upper range only
  // R4: clamp against the outside ceiling
  always_comb begin
    reg4_forced                     = wdata_i[5:0];
    reg4_forced[LDOVR_BIT_UPPER]    = 1'b1;
    next_reg4_code                  = (reg4_forced > reg4_ceiling_i) ? reg4_ceiling_i : reg4_forced;
    // a low ceiling must not drop the code out of the upper range
    next_reg4_code[LDOVR_BIT_UPPER] = 1'b1;
  end

  // R1: reload reg2 adjustable
  // R3: code and low-power flag
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      reg2_en  <= otp_reg2_adj_i[LDOVR_BIT_ENABLE];
      reg2_lp  <= LDOVR_RST_LOWPWR;
      reg2_adj <= otp_reg2_adj_i[5:0];
    end else if (wr_reg2_adj) begin
      reg2_en  <= wdata_i[LDOVR_BIT_ENABLE];
      reg2_lp  <= wdata_i[LDOVR_BIT_LOWPWR];
      reg2_adj <= next_reg2_code;
    end
  end

  // R1: reload reg3 operating
  // R9: chooser bit
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      reg3_chooser <= LDOVR_RST_CHOOSER;
      reg3_op      <= otp_reg3_op_i;
    end else if (wr_reg3_op) begin
      reg3_chooser <= wdata_i[LDOVR_BIT_CHOOSER];
      reg3_op      <= next_reg3_code;
    end
  end

  // R3: reg3 adjustable fields
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      reg3_en  <= otp_reg3_adj_i[LDOVR_BIT_ENABLE];
      reg3_lp  <= LDOVR_RST_LOWPWR;
      reg3_adj <= otp_reg3_adj_i[5:0];
    end else if (wr_reg3_adj) begin
      reg3_en  <= wdata_i[LDOVR_BIT_ENABLE];
      reg3_lp  <= wdata_i[LDOVR_BIT_LOWPWR];
      reg3_adj <= next_reg3_code;
    end
  end

  // R7: reload with top bit set
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      reg4_chooser <= LDOVR_RST_CHOOSER;
      reg4_op      <= {1'b1, otp_reg4_op_i[4:0]};
    end else if (wr_reg4_op) begin
      reg4_chooser <= wdata_i[LDOVR_BIT_CHOOSER];
      reg4_op      <= next_reg4_code;
    end
  end

  // R6: reserved bits read zero
  // a read in the same cycle as a write returns the old contents
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      rdata_o <= LDOVR_RD_UNMAPPED;
    end else if (rd_en_i) begin
      case (addr_i)
        LDOVR_OFS_REG2_ADJ:  rdata_o <= {reg2_en, reg2_lp, reg2_adj};
        LDOVR_OFS_REG2_CEIL: rdata_o <= {2'b00, reg2_ceil};
        LDOVR_OFS_REG3_OP:   rdata_o <= {1'b0, reg3_chooser, reg3_op};
        LDOVR_OFS_REG3_ADJ:  rdata_o <= {reg3_en, reg3_lp, reg3_adj};
        LDOVR_OFS_REG3_CEIL: rdata_o <= {2'b00, reg3_ceil};
        LDOVR_OFS_REG4_OP:   rdata_o <= {1'b0, reg4_chooser, reg4_op};
        default:             rdata_o <= LDOVR_RD_UNMAPPED;
      endcase
    end
  end

  // R2: forced shutdown overrides enable
  // outputs trail the registers by one edge so each leaves a flip-flop
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      reg2_enable_o    <= 1'b0;
      reg2_low_power_o <= 1'b0;
      reg2_adj_code_o  <= 6'h00;
    end else begin
      reg2_enable_o    <= reg2_en && !force_off_i;
      reg2_low_power_o <= reg2_lp;
      reg2_adj_code_o  <= reg2_adj;
    end
  end

  // R2: forced shutdown overrides enable
  // R9: chooser picks the driving code
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      reg3_enable_o    <= 1'b0;
      reg3_low_power_o <= 1'b0;
      reg3_level_o     <= 6'h00;
    end else begin
      reg3_enable_o    <= reg3_en && !force_off_i;
      reg3_low_power_o <= reg3_lp;
      reg3_level_o     <= reg3_chooser ? reg3_adj : reg3_op;
    end
  end

  // R9: chooser handed on with the code
  // the adjustable register of regulator 4 lives outside, so the choice is made there
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      reg4_op_code_o      <= 6'h00;
      reg4_bank_chooser_o <= 1'b0;
    end else begin
      reg4_op_code_o      <= reg4_op;
      reg4_bank_chooser_o <= reg4_chooser;
    end
  end
endmodule

// ### core/ldovr_pkg.sv
/*
  package for the regulator level register bank: register offsets, field
  positions, reset values and the ceiling values that leave the ceiling open.
  assumes 8-bit register data and 8-bit register addresses.
*/
package ldovr_pkg;

  localparam logic [7:0] LDOVR_OFS_REG2_ADJ  = 8'h14;
  localparam logic [7:0] LDOVR_OFS_REG2_CEIL = 8'h15;
  localparam logic [7:0] LDOVR_OFS_REG3_OP   = 8'h16;
  localparam logic [7:0] LDOVR_OFS_REG3_ADJ  = 8'h17;
  localparam logic [7:0] LDOVR_OFS_REG3_CEIL = 8'h18;
  localparam logic [7:0] LDOVR_OFS_REG4_OP   = 8'h19;

  localparam int unsigned LDOVR_BIT_ENABLE   = 7;
  localparam int unsigned LDOVR_BIT_LOWPWR   = 6;
  localparam int unsigned LDOVR_BIT_CHOOSER  = 6;
  localparam int unsigned LDOVR_BIT_UPPER    = 5;
  localparam int unsigned LDOVR_CODE_W       = 6;

  localparam logic       LDOVR_RST_LOWPWR  = 1'b0;
  localparam logic       LDOVR_RST_CHOOSER = 1'b0;
  localparam logic [7:0] LDOVR_RD_UNMAPPED = 8'h00;

  // ceiling values that do not lock the ceiling
  localparam logic [5:0] LDOVR_CEIL_OPEN_HI = 6'h3f;
  localparam logic [5:0] LDOVR_CEIL_OPEN_LO = 6'h00;

endpackage

// ### core/ldovr_ceiling.sv
/*
  one ceiling register with its lock: holds the 6-bit ceiling code and
  freezes it once a locking value is loaded.
  assumes reset is the power-on reset that reloads the programmable defaults.
*/
`timescale 1ns/100ps
module ldovr_ceiling (
  input  wire logic                             ref_clk_i,
  input  wire logic                             rstn_i,
  input  wire logic [ldovr_pkg::LDOVR_CODE_W-1:0] otp_ceiling_i,
  input  wire logic                             wr_i,
  input  wire logic [ldovr_pkg::LDOVR_CODE_W-1:0] wdata_i,
  output logic      [ldovr_pkg::LDOVR_CODE_W-1:0] ceiling_o,
  output logic                                  locked_o
);
  import ldovr_pkg::*;

  function automatic logic locks(input logic [LDOVR_CODE_W-1:0] v);
    locks = (v != LDOVR_CEIL_OPEN_HI) && (v != LDOVR_CEIL_OPEN_LO);
  endfunction

  // R1: reload on reset
  // R5: lock on load
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      ceiling_o <= otp_ceiling_i;
      locked_o  <= locks(otp_ceiling_i);
    end else if (wr_i && !locked_o) begin
      ceiling_o <= wdata_i;
      locked_o  <= locks(wdata_i);
    end
  end
endmodule

// ### sim/ldovr_properties.sv
/* port checker for the level register bank.
   bound from the bench top; sees only bank ports. */
`timescale 1ns/100ps
module ldovr_properties (
  input wire logic       ref_clk_i,
  input wire logic       rstn_i,
  input wire logic       wr_en_i,
  input wire logic       rd_en_i,
  input wire logic       force_off_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic       reg2_enable_o,
  input wire logic       reg3_enable_o,
  input wire logic       reg2_low_power_o,
  input wire logic       reg3_low_power_o,
  input wire logic [5:0] reg2_adj_code_o,
  input wire logic [5:0] reg4_op_code_o,
  input wire logic [5:0] reg4_ceiling_i
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  wire logic       w19 = wr_en_i && addr_i == 8'h19;
  wire logic [1:0] top = wdata_i[7:6];
  wire logic [5:0] lo  = wdata_i[5:0];
  function automatic logic [5:0] cl4(logic [5:0] w, c);
    return ({1'b1, w[4:0]} > c) ? {1'b1, c[4:0]} : {1'b1, w[4:0]};
  endfunction
  a_shutdown_off: assert property (
    force_off_i |=> !reg2_enable_o && !reg3_enable_o) else $error("enable under shutdown");
  a_adj_write: assert property (
    wr_en_i && addr_i == 8'h14 ##1 !wr_en_i && !force_off_i ##1 !force_off_i
    |=> {reg2_enable_o, reg2_low_power_o} == $past(top, 3)) else $error("adjustable write");
  a_code_hold: assert property (
    $past(rstn_i, 2) && !$past(wr_en_i) && !$past(wr_en_i, 2) |-> $stable(reg2_adj_code_o))
    else $error("code moved without write");
  a_reg4_clamp: assert property (
    w19 ##1 !w19 ##1 1'b1 |=> reg4_op_code_o == cl4($past(lo, 3), $past(reg4_ceiling_i, 3)))
    else $error("reg4 clamp");
  a_reg4_upper: assert property (
    $past(rstn_i) |-> reg4_op_code_o[5]) else $error("reg4 top bit");
  a_lowpwr_reset: assert property (
    $rose(rstn_i) |=> !reg2_low_power_o && !reg3_low_power_o) else $error("low-power reset");
  a_unmapped_zero: assert property (
    rd_en_i && (addr_i < 8'h14 || addr_i > 8'h19) |=> rdata_o == 8'h00) else $error("unmapped");
  a_ceil_rsvd: assert property (
    rd_en_i && (addr_i == 8'h15 || addr_i == 8'h18) |=> rdata_o[7:6] == 2'b00)
    else $error("ceiling reserved");
  a_op_rsvd: assert property (
    rd_en_i && (addr_i == 8'h16 || addr_i == 8'h19) |=> !rdata_o[7]) else $error("op reserved");
  c_adj: cover property (wr_en_i && addr_i == 8'h14);
  c_shut: cover property ($rose(force_off_i));
  c_unmap: cover property (rd_en_i && addr_i > 8'h19);
endmodule

// ### sim/ldovr_host.sv
/* host model: single-byte register strobes.
   assumes the bank samples on the rising clock edge. */
`timescale 1ns/100ps
module ldovr_host (
  input  wire logic       clk_i,
  output logic            wr_en_o,
  output logic            rd_en_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o
);
  initial {wr_en_o, rd_en_o, addr_o, wdata_o} = 18'h0;
  function automatic logic [7:0] msk(input logic [7:0] a, d);
    return (a == 8'h15 || a == 8'h18) ? d & 8'h3f : (a == 8'h16 || a == 8'h19) ? d & 8'h7f : d;
  endfunction
  task automatic xfer(input logic w, input logic [7:0] a, d);
    @(posedge clk_i);
    #1 {wr_en_o, rd_en_o, addr_o, wdata_o} = {w, !w, a, msk(a, d)};
    @(posedge clk_i);
    // released bus shows no stale value
    #1 {wr_en_o, rd_en_o, addr_o, wdata_o} = {2'b00, ~addr_o, ~wdata_o};
  endtask
endmodule

// ### sim/ldovr_bank_tb.sv
/* bench: random traffic against a register model, two resets.
   assumes package, bank, host and checker compiled first. */
`timescale 1ns/100ps
module ldovr_bank_tb;
  logic       clk = 0, rstn = 0, foff = 0, wr, rd, e2, l2, e3, l3, s4;
  logic [7:0] addr, wd, rdat, o2a, o3a, m [8'h14:8'h19];
  logic [5:0] o2c, o3c, o3o, o4o, c4, k2, v3, k4;
  bit         lk [8'h15:8'h18];
  int         errors = 0, n_compared = 0, cyc = 0, seed = 32'h261db23d;
  always #25 clk = ~clk;
  always @(posedge clk) if (++cyc == 10000) begin
    errors++;
    test_done();
  end
  ldovr_host i_ldovr_host (.clk_i(clk), .wr_en_o(wr), .rd_en_o(rd), .addr_o(addr), .wdata_o(wd));
  ldovr_bank i_ldovr_bank (.ref_clk_i(clk), .rstn_i(rstn), .wr_en_i(wr), .rd_en_i(rd),
    .addr_i(addr), .wdata_i(wd), .rdata_o(rdat), .force_off_i(foff), .otp_reg2_adj_i(o2a),
    .otp_reg2_ceil_i(o2c), .otp_reg3_op_i(o3o), .otp_reg3_adj_i(o3a), .otp_reg3_ceil_i(o3c),
    .otp_reg4_op_i(o4o), .reg4_ceiling_i(c4), .reg2_enable_o(e2), .reg2_low_power_o(l2),
    .reg2_adj_code_o(k2), .reg3_enable_o(e3), .reg3_low_power_o(l3), .reg3_level_o(v3),
    .reg4_op_code_o(k4), .reg4_bank_chooser_o(s4));
  task automatic chk(input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic outs();
    logic [22:0] x;
    x = {m[8'h14][7] & !foff, m[8'h14][6:0], m[8'h17][7] & !foff, m[8'h17][6],
         m[8'h16][6] ? m[8'h17][5:0] : m[8'h16][5:0], m[8'h19][5:0], m[8'h19][6]};
    chk({e2, l2, k2, e3, l3, v3, k4, s4}, x);
  endtask
  task automatic rd_chk(input logic [7:0] a);
    i_ldovr_host.xfer(0, a, 8'h00);
    chk(rdat, (a > 8'h13 && a < 8'h1a) ? m[a] : 8'h00);
  endtask
  // open ceilings first, then random odd ones that lock from reset unless 0x3f
  task automatic do_reset(input bit rnd);
    {rstn, foff, c4} = {2'b00, 6'h3f};
    o2c = rnd ? 6'($random(seed)) | 6'h01 : 6'h3f;
    o3c = rnd ? 6'($random(seed)) | 6'h01 : 6'h3f;
    o2a = 8'($random(seed)) & {2'b11, o2c};
    o3a = 8'($random(seed)) & {2'b11, o3c};
    o3o = 6'($random(seed)) & o3c;
    o4o = 6'($random(seed));
    m[8'h14] = {o2a[7], 1'b0, o2a[5:0]};
    m[8'h15] = {2'b00, o2c};
    m[8'h16] = {2'b00, o3o};
    m[8'h17] = {o3a[7], 1'b0, o3a[5:0]};
    m[8'h18] = {2'b00, o3c};
    m[8'h19] = {3'b001, o4o[4:0]};
    lk[8'h15] = o2c != 6'h3f && o2c != 6'h00;
    lk[8'h18] = o3c != 6'h3f && o3c != 6'h00;
    repeat (12) @(posedge clk);
    #1 rstn = 1;
    @(posedge clk);
    #1 outs();
  endtask
  task automatic op();
    logic [7:0] a, w;
    logic [5:0] v, c;
    a = 8'h12 + 8'({$random(seed)} % 10);
    w = i_ldovr_host.msk(a, 8'($random(seed)));
    foff = 1'($random(seed));
    c4 = 6'($random(seed));
    c = m[a < 8'h16 ? 8'h15 : 8'h18][5:0];
    v = w[5:0] > c ? c : w[5:0];
    i_ldovr_host.xfer(1, a, w);
    case (a)
      8'h14, 8'h17: m[a] = {w[7:6], v};
      8'h16: m[a] = {1'b0, w[6], v};
      8'h19: begin
        v = {1'b1, w[4:0]} > c4 ? c4 : {1'b1, w[4:0]};
        m[a] = {1'b0, w[6], 1'b1, v[4:0]};
      end
      8'h15, 8'h18: if (!lk[a]) begin
        m[a] = w;
        lk[a] = w != 8'h3f && w != 8'h00;
      end
      default: ;
    endcase
    @(posedge clk);
    #1 outs();
    rd_chk(a);
  endtask
  initial begin
    for (int ph = 0; ph < 2; ph++) begin
      do_reset(ph[0]);
      for (int a = 8'h12; a < 8'h1c; a++) rd_chk(8'(a));
      repeat (150) op();
    end
    test_done();
  end
endmodule
bind ldovr_bank ldovr_properties i_ldovr_properties (.ref_clk_i, .rstn_i, .wr_en_i, .rd_en_i,
  .force_off_i, .addr_i, .wdata_i, .rdata_o, .reg2_enable_o, .reg3_enable_o, .reg2_low_power_o,
  .reg3_low_power_o, .reg2_adj_code_o, .reg4_op_code_o, .reg4_ceiling_i);
